// ### core/fbep_pkg.sv
// Package: constants and carriers for the flash block erase and protect logic
package fbep_pkg;
  localparam int FBEP_ADDR_W = 15;
  localparam int FBEP_WORD_W = 32;
  localparam int FBEP_NBLK = 32;
  localparam int FBEP_NUNIT = 16;
  localparam int FBEP_BLK_W = 5;
  localparam int FBEP_UNIT_W = 4;
  localparam int FBEP_WIDX_W = 8;
  localparam int FBEP_BLK_LSB = 10;
  localparam int FBEP_UNIT_LSB = 11;
  localparam int FBEP_WORD_LSB = 2;
  localparam int FBEP_WPB = 256;
  localparam logic [FBEP_WORD_W-1:0] FBEP_ERASED = 32'hFFFFFFFF;
  localparam logic [FBEP_NUNIT-1:0] FBEP_PROT_RST = 16'h0000;
  localparam logic [FBEP_WIDX_W-1:0] FBEP_WIDX_LAST = 8'hFF;

  typedef enum logic [1:0] {
    FBEP_SRC_FETCH = 2'b00,
    FBEP_SRC_DATA = 2'b01,
    FBEP_SRC_DEBUG = 2'b10
  } fbep_src_t;

  typedef enum logic [1:0] {
    FBEP_OP_READ = 2'b00,
    FBEP_OP_PROG = 2'b01,
    FBEP_OP_ERASE = 2'b10
  } fbep_op_t;

  typedef enum logic [1:0] {
    FBEP_ST_IDLE = 2'b00,
    FBEP_ST_ERASE = 2'b01
  } fbep_state_t;

  typedef struct packed {
    logic valid;
    fbep_src_t src;
    fbep_op_t op;
    logic [FBEP_ADDR_W-1:0] addr;
    logic [FBEP_WORD_W-1:0] wdata;
  } fbep_req_t;

  typedef struct packed {
    logic done;
    logic denied;
    logic [FBEP_WORD_W-1:0] rdata;
  } fbep_rsp_t;
endpackage

// ### core/fbep_check.sv
// Access checker: decides whether a request is allowed on a protection unit
`timescale 1ns/1ps
module fbep_check (
  input wire fbep_pkg::fbep_src_t src,
  input wire fbep_pkg::fbep_op_t op,
  input wire logic ro,
  input wire logic xo,
  output logic allow
);
  import fbep_pkg::*;
  always_comb begin
    allow = 1'b1;
    if (op != FBEP_OP_READ) begin
      if (ro || xo) begin
        allow = 1'b0;
      end
    end else if (xo && src != FBEP_SRC_FETCH) begin
      allow = 1'b0;
    end
  end
endmodule

// ### core/fbep_top.sv
// Flash array with per-block erase and per-unit read/execute-only protection
// Summary of operation
// - 32 KB array, 1 KB independently erasable blocks
// - Erased block reads back all ones
// - Protection per 2 KB unit, independent
// - Each unit read-only or execute-only
// - Read-only unit refuses erase and program
// - Execute-only unit refuses erase and program
// - Execute-only returns data only to fetch
`timescale 1ns/1ps
module fbep_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire fbep_pkg::fbep_req_t REQ,
  input wire logic [fbep_pkg::FBEP_NUNIT-1:0] PROT_RO,
  input wire logic [fbep_pkg::FBEP_NUNIT-1:0] PROT_XO,
  output fbep_pkg::fbep_rsp_t RSP,
  output logic BUSY
);
  import fbep_pkg::*;

  typedef struct packed {
    fbep_state_t state;
    logic [FBEP_BLK_W-1:0] blk;
    logic [FBEP_WIDX_W-1:0] widx;
    logic [FBEP_NUNIT-1:0] ro;
    logic [FBEP_NUNIT-1:0] xo;
    logic busy;
    fbep_rsp_t rsp;
  } fbep_ctl_t;

  // Array storage; not reset, like a real flash it keeps contents
  logic [FBEP_WORD_W-1:0] mem_ff [0:FBEP_NBLK*FBEP_WPB-1];
  fbep_ctl_t ctl_ff;
  fbep_ctl_t nxt_ctl;
  logic allow;
  logic [FBEP_UNIT_W-1:0] unit;
  logic [FBEP_ADDR_W-FBEP_WORD_LSB-1:0] widx_addr;
  logic [FBEP_ADDR_W-FBEP_WORD_LSB-1:0] erase_addr;
  logic mem_we;
  logic [FBEP_ADDR_W-FBEP_WORD_LSB-1:0] mem_wa;
  logic [FBEP_WORD_W-1:0] mem_wd;
  logic take;

  assign unit = REQ.addr[FBEP_ADDR_W-1:FBEP_UNIT_LSB];
  assign widx_addr = REQ.addr[FBEP_ADDR_W-1:FBEP_WORD_LSB];
  assign erase_addr = {ctl_ff.blk, ctl_ff.widx};
  assign take = REQ.valid && ctl_ff.state == FBEP_ST_IDLE;

  // Protection bits are registered to keep the check off the strap paths
  fbep_check u_check (
    .src(REQ.src),
    .op(REQ.op),
    .ro(ctl_ff.ro[unit]),
    .xo(ctl_ff.xo[unit]),
    .allow(allow)
  );

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_ctl.ro = PROT_RO;
    nxt_ctl.xo = PROT_XO;
    nxt_ctl.rsp.done = 1'b0;
    nxt_ctl.rsp.denied = 1'b0;
    mem_we = 1'b0;
    mem_wa = widx_addr;
    mem_wd = REQ.wdata;
    case (ctl_ff.state)
      FBEP_ST_IDLE: begin
        if (take) begin
          if (!allow) begin
            nxt_ctl.rsp.done = 1'b1;
            nxt_ctl.rsp.denied = 1'b1;
            nxt_ctl.rsp.rdata = '0;
          end else if (REQ.op == FBEP_OP_READ) begin
            nxt_ctl.rsp.done = 1'b1;
            nxt_ctl.rsp.rdata = mem_ff[widx_addr];
          end else if (REQ.op == FBEP_OP_PROG) begin
            // Flash programming only clears bits
            mem_we = 1'b1;
            mem_wd = mem_ff[widx_addr] & REQ.wdata;
            nxt_ctl.rsp.done = 1'b1;
          end else begin
            nxt_ctl.state = FBEP_ST_ERASE;
            nxt_ctl.blk = REQ.addr[FBEP_ADDR_W-1:FBEP_BLK_LSB];
            nxt_ctl.widx = '0;
          end
        end
      end
      FBEP_ST_ERASE: begin
        // One word per cycle; only the selected block is touched
        mem_we = 1'b1;
        mem_wa = erase_addr;
        mem_wd = FBEP_ERASED;
        nxt_ctl.widx = ctl_ff.widx + 8'h01;
        if (ctl_ff.widx == FBEP_WIDX_LAST) begin
          nxt_ctl.state = FBEP_ST_IDLE;
          nxt_ctl.rsp.done = 1'b1;
        end
      end
      default: begin
        nxt_ctl.state = FBEP_ST_IDLE;
      end
    endcase
    // Busy is registered so the port comes straight from a flop
    nxt_ctl.busy = nxt_ctl.state != FBEP_ST_IDLE;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_ff <= '{state: FBEP_ST_IDLE, blk: '0, widx: '0,
                  ro: FBEP_PROT_RST, xo: FBEP_PROT_RST, busy: 1'b0,
                  rsp: '0};
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem_ff[mem_wa] <= mem_wd;
    end
  end

  assign RSP = ctl_ff.rsp;
  assign BUSY = ctl_ff.busy;
endmodule

// ### test/fbep_sva.sv
// Assertions on the flash block ports
`timescale 1ns/1ps
module fbep_sva (
  input wire logic CLK,
  input wire logic RSTN,
  input wire fbep_pkg::fbep_req_t REQ,
  input wire logic [15:0] PROT_RO,
  input wire logic [15:0] PROT_XO,
  input wire fbep_pkg::fbep_rsp_t RSP,
  input wire logic BUSY
);
  import fbep_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // The design acts on protection one cycle late, so mirror that here
  logic [15:0] ro_q;
  logic [15:0] xo_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ro_q <= 16'h0000;
      xo_q <= 16'h0000;
    end else begin
      ro_q <= PROT_RO;
      xo_q <= PROT_XO;
    end
  end
  wire t = REQ.valid && !BUSY;
  wire r = t && REQ.op == FBEP_OP_READ;
  wire f = REQ.src == FBEP_SRC_FETCH;
  wire x = xo_q[REQ.addr[14:11]];
  wire k = x || ro_q[REQ.addr[14:11]];
  wire e = t && REQ.op == FBEP_OP_ERASE && !k;
  sequence s_erase; ##1 BUSY [*8] ##249 RSP.done && !BUSY; endsequence
  AST_LOCK: assert property (t && !r && k |=> RSP.denied)
    else $error("locked write ran");
  AST_XO: assert property (r && x && !f |=> RSP.denied)
    else $error("hidden read served");
  AST_XO_ZERO: assert property (r && x && !f |=> RSP.rdata == '0)
    else $error("hidden data shown");
  AST_FETCH: assert property (r && f |=> RSP.done && !RSP.denied)
    else $error("fetch refused");
  AST_RO: assert property (r && !x |=> RSP.done && !RSP.denied)
    else $error("read refused");
  AST_OPEN: assert property (t && !k |=> !RSP.denied)
    else $error("open unit refused");
  AST_ERASE: assert property (e |-> s_erase)
    else $error("erase timing wrong");
  AST_DONE: assert property (t && !e |=> RSP.done && !BUSY)
    else $error("no prompt answer");
endmodule
bind fbep_top fbep_sva u_sva (.*);

// ### test/fbep_cpu.sv
// Requester model for the fetch, data and debug masters
`timescale 1ns/1ps
module fbep_cpu (
  input wire logic clk,
  output fbep_pkg::fbep_req_t req
);
  import fbep_pkg::*;
  initial req = '0;
  // Code c is {source, operation}; strobe held for one edge
  task automatic go(logic [3:0] c, logic [14:0] a, logic [31:0] d);
    @(posedge clk) req <= '{1'b1, fbep_src_t'(c[3:2]),
      fbep_op_t'(c[1:0]), a, d};
    // Scramble released fields so no stale request lingers
    @(posedge clk) req <= '{1'b0, req.src, req.op, ~a, ~d};
  endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the flash block
`timescale 1ns/1ps
module tb;
  import fbep_pkg::*;
  logic CLK = 0, RSTN = 0, BUSY;
  logic [15:0] PROT_RO = '0, PROT_XO = '0;
  fbep_req_t REQ;
  fbep_rsp_t RSP;
  int n_mismatch = 0, checks = 0, cyc = 0;
  fbep_cpu u_cpu (.clk(CLK), .req(REQ));
  fbep_top u_dut (.*);
  initial forever #2.5 CLK = ~CLK;
  task give_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge CLK) if (++cyc == 2000) begin
    n_mismatch++;
    $display("MISMATCH %0t timeout", $time);
    give_verdict;
  end
  // x is expected read data, or write data for a program
  task automatic a(logic [3:0] c, logic [14:0] ad, logic d, logic [31:0] x);
    int i = 0;
    u_cpu.go(c, ad, x);
    @(negedge CLK);
    while (RSP.done !== 1'b1 && i++ < 300) @(negedge CLK);
    checks++;
    if ({RSP.done, RSP.denied} !== {1'b1, d} ||
        c[1:0] == 2'h0 && RSP.rdata !== x) begin
      n_mismatch++;
      $display("MISMATCH %0t at %h", $time, ad);
    end
  endtask
  task automatic sc_open;
    a(4'h2, 15'h0000, '0, '0);
    a(4'h8, 15'h03FC, '0, FBEP_ERASED);
    a(4'h5, 15'h0004, '0, 32'h00001234);
    a(4'h6, 15'h0400, '0, '0);
    a(4'h4, 15'h0004, '0, 32'h00001234);
  endtask
  task automatic sc_ro;
    @(posedge CLK) PROT_RO <= 16'h0001;
    a(4'h5, 15'h0004, '1, '0);
    a(4'hA, 15'h0400, '1, '0);
    a(4'h4, 15'h0004, '0, 32'h00001234);
  endtask
  task automatic sc_xo;
    @(posedge CLK) PROT_RO <= '0;
    PROT_XO <= 16'h0001;
    a(4'h0, 15'h0004, '0, 32'h00001234);
    a(4'h4, 15'h0004, '1, '0);
    a(4'h8, 15'h0004, '1, '0);
    a(4'h1, 15'h0004, '1, '0);
    a(4'h2, 15'h0000, '1, '0);
    a(4'h0, 15'h0004, '0, 32'h00001234);
    a(4'h6, 15'h0800, '0, '0);
    a(4'h8, 15'h0800, '0, FBEP_ERASED);
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    sc_open;
    sc_ro;
    sc_xo;
    give_verdict;
  end
endmodule
